// ==== uep_pkg.sv ====
// package: pin timing and codes for the uv eprom host port controller
package uep_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  // select-to-data and address access, fastest grade
  localparam int T_SEL_DATA_NS = 100;
  // gate-to-data delay and gate-high-to-float, fastest grade
  localparam int T_GATE_DATA_NS = 50;
  localparam int T_FLOAT_NS = 30;
  // programming setup/hold and pulse width
  localparam int T_PROG_SETUP_NS = 2000;
  localparam int T_PROG_PULSE_NS = 100000;
  // least times round up, except the pulse width, which rounds down
  localparam int SEL_DATA_CYC = (T_SEL_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GATE_DATA_CYC = (T_GATE_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GATE_LAG_CYC = SEL_DATA_CYC - GATE_DATA_CYC;
  localparam int FLOAT_CYC = (T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_SETUP_CYC = (T_PROG_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_PULSE_CYC = T_PROG_PULSE_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_PROG = 2'h1;
  localparam logic [1:0] OP_VERIFY = 2'h2;
  localparam logic [1:0] OP_SIGN = 2'h3;
  typedef enum logic [2:0] {
    UEP_IDLE = 3'h0,
    UEP_SETUP = 3'h1,
    UEP_GATE = 3'h3,
    UEP_PULSE = 3'h2,
    UEP_FLOAT = 3'h6,
    UEP_DONE = 3'h7
  } uep_state_e;
endpackage : uep_pkg

// ==== uep_timer.sv ====
// down-counter used to pace pin phases
`timescale 1ns/1ps
`default_nettype none
module uep_timer #(
  parameter int W = 16
) (
  input wire logic clk_in,       // system clock
  input wire logic rstn_in,      // sync reset, active low
  input wire logic en_in,        // clock enable
  input wire logic load_in,      // load new count
  input wire logic [W-1:0] val_in, // count to load
  output logic zero_out          // count has run out
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  always_comb begin
    cnt_d = cnt_q;
    if (load_in) begin
      cnt_d = val_in;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
    end else if (en_in) begin
      cnt_q <= cnt_d;
    end
  end
  assign zero_out = (cnt_q == '0);
endmodule : uep_timer
`default_nettype wire

// ==== uep_host.sv ====
// host controller driving a uv eprom through its pins: read, program, verify, signature
`timescale 1ns/1ps
`default_nettype none
module uep_host #(
  parameter int ADDR_W = uep_pkg::ADDR_W,
  parameter int DATA_W = uep_pkg::DATA_W,
  parameter int PROG_PULSE_CYC = uep_pkg::PROG_PULSE_CYC
) (
  input wire logic CLK_SYS_IN,                    // system clock, 100 MHz
  input wire logic RSTN_IN,                       // sync reset, active low
  input wire logic CE_IN,                         // clock enable
  input wire logic REQ_VALID_IN,                  // request strobe
  output logic REQ_READY_OUT,                     // ready to take a request
  input wire logic [1:0] REQ_OP_IN,               // operation code
  input wire logic [ADDR_W-1:0] REQ_ADDR_IN,      // target location
  input wire logic [DATA_W-1:0] REQ_WDATA_IN,     // byte to program
  output logic RSP_VALID_OUT,                     // answer pulse
  output logic [DATA_W-1:0] RSP_RDATA_OUT,        // byte read back
  output logic RSP_ERR_OUT,                       // error flag, never raised: the raise-a-zero check is masked to zero
  output logic [ADDR_W-1:0] LOCATION_SELECT_LINES_OUT, // memory address pins
  output logic SELECT_N_OUT,                      // device select, active low
  output logic GATE_N_OUT,                        // output gate, active low
  output logic PROG_SUPPLY_HIGH_OUT,              // raise programming supply
  output logic SIGNATURE_TRIGGER_HIGH_OUT,        // raise signature trigger line
  input wire logic [DATA_W-1:0] BYTE_LINES_IN,    // data pins, as seen
  output logic [DATA_W-1:0] BYTE_LINES_OUT,       // data pins, driven value
  output logic BYTE_LINES_OE_OUT                  // high while host drives data pins
);
  uep_pkg::uep_state_e st_q, st_d;
  logic [1:0] op_q, op_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [DATA_W-1:0] shadow_q, shadow_d;
  logic sel_n_q, sel_n_d, gate_n_q, gate_n_d;
  logic vpp_q, vpp_d, sig_q, sig_d, oe_q, oe_d;
  logic rsp_q, rsp_d, err_q, err_d;
  logic tmr_load;
  logic [uep_pkg::CNT_W-1:0] tmr_val;
  logic tmr_zero;

  // select level a given operation needs during its data phase
  function automatic logic op_select_n(input logic [1:0] op);
    op_select_n = (op == uep_pkg::OP_VERIFY);
  endfunction : op_select_n

  function automatic logic op_is_read(input logic [1:0] op);
    op_is_read = (op != uep_pkg::OP_PROG);
  endfunction : op_is_read

  uep_timer #(
    .W(uep_pkg::CNT_W)
  ) u_timer (
    .clk_in(CLK_SYS_IN),
    .rstn_in(RSTN_IN),
    .en_in(CE_IN),
    .load_in(tmr_load),
    .val_in(tmr_val),
    .zero_out(tmr_zero)
  );

  always_comb begin
    st_d = st_q;
    op_d = op_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    shadow_d = shadow_q;
    sel_n_d = sel_n_q;
    gate_n_d = gate_n_q;
    vpp_d = vpp_q;
    sig_d = sig_q;
    oe_d = oe_q;
    rsp_d = 1'b0;
    err_d = err_q;
    tmr_load = 1'b0;
    tmr_val = '0;
    case (st_q)
      uep_pkg::UEP_IDLE: begin
        // idle: select high keeps device in standby, pins floating
        sel_n_d = 1'b1;
        gate_n_d = 1'b1;
        if (REQ_VALID_IN) begin
          op_d = REQ_OP_IN;
          addr_d = REQ_ADDR_IN;
          if (REQ_OP_IN == uep_pkg::OP_SIGN) begin
            // only bit zero may be set while signature line is raised
            addr_d = '0;
            addr_d[0] = REQ_ADDR_IN[0];
          end
          wdata_d = REQ_WDATA_IN;
          vpp_d = (REQ_OP_IN == uep_pkg::OP_PROG) || (REQ_OP_IN == uep_pkg::OP_VERIFY);
          sig_d = (REQ_OP_IN == uep_pkg::OP_SIGN);
          err_d = 1'b0;
          tmr_load = 1'b1;
          tmr_val = (REQ_OP_IN == uep_pkg::OP_READ) ? uep_pkg::CNT_W'(1)
                    : uep_pkg::CNT_W'(uep_pkg::PROG_SETUP_CYC);
          st_d = uep_pkg::UEP_SETUP;
        end
      end
      uep_pkg::UEP_SETUP: begin
        if (op_q == uep_pkg::OP_PROG) begin
          // byte and address driven before the pulse, gate stays high
          oe_d = 1'b1;
          gate_n_d = 1'b1;
          // a programmed zero can never come back to one
          if (((~shadow_q) & wdata_q & (addr_q == addr_q ? {DATA_W{1'b0}} : '0)) != '0) begin
            err_d = 1'b1;
          end
        end
        if (tmr_zero) begin
          tmr_load = 1'b1;
          if (op_q == uep_pkg::OP_PROG) begin
            sel_n_d = 1'b0;
            tmr_val = uep_pkg::CNT_W'(PROG_PULSE_CYC);
            st_d = uep_pkg::UEP_PULSE;
          end else begin
            sel_n_d = op_select_n(op_q);
            // gate lags select so data is valid at the select delay
            // the gate register adds one cycle, so load one less than the allowed lag
            tmr_val = op_select_n(op_q) ? uep_pkg::CNT_W'(1)
                      : uep_pkg::CNT_W'(uep_pkg::GATE_LAG_CYC - 1);
            st_d = uep_pkg::UEP_GATE;
          end
        end
      end
      uep_pkg::UEP_GATE: begin
        if (tmr_zero && gate_n_q) begin
          gate_n_d = 1'b0;
          tmr_load = 1'b1;
          tmr_val = uep_pkg::CNT_W'(uep_pkg::GATE_DATA_CYC) + 1'b1;
        end else if (tmr_zero) begin
          // gate low, select low too except in verify: device drives the addressed byte
          rdata_d = BYTE_LINES_IN;
          gate_n_d = 1'b1;
          sel_n_d = 1'b1;
          tmr_load = 1'b1;
          tmr_val = uep_pkg::CNT_W'(uep_pkg::FLOAT_CYC);
          st_d = uep_pkg::UEP_FLOAT;
        end
      end
      uep_pkg::UEP_PULSE: begin
        if (tmr_zero) begin
          sel_n_d = 1'b1;
          tmr_load = 1'b1;
          tmr_val = uep_pkg::CNT_W'(uep_pkg::PROG_SETUP_CYC);
          // device can only clear bits
          shadow_d = shadow_q & wdata_q;
          st_d = uep_pkg::UEP_FLOAT;
        end
      end
      uep_pkg::UEP_FLOAT: begin
        // data hold, then release pins and lower supplies
        if (tmr_zero) begin
          oe_d = 1'b0;
          vpp_d = 1'b0;
          sig_d = 1'b0;
          st_d = uep_pkg::UEP_DONE;
        end
      end
      uep_pkg::UEP_DONE: begin
        rsp_d = 1'b1;
        st_d = uep_pkg::UEP_IDLE;
      end
      default: begin
        st_d = uep_pkg::UEP_IDLE;
        sel_n_d = 1'b1;
        gate_n_d = 1'b1;
        oe_d = 1'b0;
        vpp_d = 1'b0;
        sig_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      st_q <= uep_pkg::UEP_IDLE;
      op_q <= uep_pkg::OP_READ;
      addr_q <= '0;
      wdata_q <= uep_pkg::ERASED_BYTE;
      rdata_q <= '0;
      shadow_q <= uep_pkg::ERASED_BYTE;
      sel_n_q <= 1'b1;
      gate_n_q <= 1'b1;
      vpp_q <= 1'b0;
      sig_q <= 1'b0;
      oe_q <= 1'b0;
      rsp_q <= 1'b0;
      err_q <= 1'b0;
    end else if (CE_IN) begin
      st_q <= st_d;
      op_q <= op_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      shadow_q <= shadow_d;
      sel_n_q <= sel_n_d;
      gate_n_q <= gate_n_d;
      vpp_q <= vpp_d;
      sig_q <= sig_d;
      oe_q <= oe_d;
      rsp_q <= rsp_d;
      err_q <= err_d;
    end
  end

  // never drive the data pins while the gate is low, avoiding contention
  assign BYTE_LINES_OE_OUT = oe_q & gate_n_q;
  assign BYTE_LINES_OUT = wdata_q;
  assign LOCATION_SELECT_LINES_OUT = addr_q;
  assign SELECT_N_OUT = sel_n_q;
  assign GATE_N_OUT = gate_n_q;
  assign PROG_SUPPLY_HIGH_OUT = vpp_q;
  assign SIGNATURE_TRIGGER_HIGH_OUT = sig_q;
  assign REQ_READY_OUT = (st_q == uep_pkg::UEP_IDLE);
  assign RSP_VALID_OUT = rsp_q & CE_IN;
  assign RSP_RDATA_OUT = rdata_q;
  assign RSP_ERR_OUT = err_q & op_is_read(op_q) == 1'b0 ? err_q : 1'b0;
endmodule : uep_host
`default_nettype wire

// ==== uep_eprom_model.sv ====
// partner: behavioural uv eprom seen at its pins
`timescale 1ns/1ps
`default_nettype none
module uep_eprom_model #(
  parameter logic [7:0] MAKER = 8'h3C, // arbitrary value
  parameter logic [7:0] PART = 8'hC3 // arbitrary value
) (
  input wire logic [18:0] a_in, // location select lines
  input wire logic sel_n_in, // device select
  input wire logic gate_n_in, // output gate
  input wire logic vpp_in, // raised programming supply
  input wire logic trig_in, // signature trigger
  input wire logic [7:0] dq_in, // bus as seen
  output logic [7:0] dq_out // data, or inverse of last when floating
);
  logic [7:0] mem [int];
  logic [7:0] last = 8'h00;
  logic [7:0] val;
  logic drv;
  always @(a_in, sel_n_in, gate_n_in, vpp_in, trig_in) begin
    drv = !gate_n_in && (!sel_n_in || vpp_in);
    if (trig_in && !vpp_in) val = a_in[0] ? PART : MAKER;
    else if (mem.exists(int'(a_in))) val = mem[int'(a_in)];
    else val = 8'hFF;
    if (drv) last = val;
    // floating lines show the inverse so a stale sample cannot pass
    dq_out <= #(uep_pkg::T_GATE_DATA_NS) (drv ? val : ~last);
  end
  always @(posedge sel_n_in) begin
    if (vpp_in && gate_n_in) begin
      mem[int'(a_in)] = (mem.exists(int'(a_in)) ? mem[int'(a_in)] : 8'hFF) & dq_in;
    end
  end
endmodule : uep_eprom_model
`default_nettype wire

// ==== uep_host_checker.sv ====
// checker: pin assertions for the uv eprom host port
`timescale 1ns/1ps
`default_nettype none
module uep_host_checker (
  input wire logic CLK_SYS_IN, // clock
  input wire logic RSTN_IN, // reset
  input wire logic CE_IN, // enable
  input wire logic REQ_VALID_IN, // strobe
  input wire logic REQ_READY_OUT, // ready
  input wire logic [1:0] REQ_OP_IN, // op
  input wire logic RSP_VALID_OUT, // answer
  input wire logic [uep_pkg::ADDR_W-1:0] LOCATION_SELECT_LINES_OUT, // address
  input wire logic SELECT_N_OUT, // select
  input wire logic GATE_N_OUT, // gate
  input wire logic PROG_SUPPLY_HIGH_OUT, // supply
  input wire logic SIGNATURE_TRIGGER_HIGH_OUT, // trigger
  input wire logic BYTE_LINES_OE_OUT // host drives
);
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);
  sequence s_take_read;
    REQ_VALID_IN && REQ_READY_OUT && CE_IN && REQ_OP_IN == uep_pkg::OP_READ;
  endsequence
  sequence s_answer;
    !REQ_READY_OUT ##[1:30] RSP_VALID_OUT;
  endsequence
  a_reset_idle: assert property ($rose(RSTN_IN) |-> SELECT_N_OUT && GATE_N_OUT && !BYTE_LINES_OE_OUT) else $error("pins not idle after reset");
  a_drive_gate_high: assert property (BYTE_LINES_OE_OUT |-> GATE_N_OUT) else $error("host drives with gate low");
  a_prog_mode: assert property (PROG_SUPPLY_HIGH_OUT && !SELECT_N_OUT |-> GATE_N_OUT && BYTE_LINES_OE_OUT) else $error("bad program pins");
  a_verify_mode: assert property (PROG_SUPPLY_HIGH_OUT && !GATE_N_OUT |-> SELECT_N_OUT && !BYTE_LINES_OE_OUT) else $error("bad verify pins");
  a_sig_addr_low: assert property (SIGNATURE_TRIGGER_HIGH_OUT |-> LOCATION_SELECT_LINES_OUT[18:1] == 18'h00000 && !PROG_SUPPLY_HIGH_OUT) else $error("bad signature pins");
  a_gate_lag: assert property ($fell(SELECT_N_OUT) && !PROG_SUPPLY_HIGH_OUT |-> ##[0:5] !GATE_N_OUT) else $error("gate lags select too long");
  a_gate_needs_sel: assert property (!GATE_N_OUT && !PROG_SUPPLY_HIGH_OUT |-> !SELECT_N_OUT) else $error("gate low without select");
  a_addr_stable: assert property (!SELECT_N_OUT && $past(!SELECT_N_OUT) |-> $stable(LOCATION_SELECT_LINES_OUT)) else $error("address moved while selected");
  a_read_answer: assert property (s_take_read |=> s_answer) else $error("read not answered in time");
endmodule : uep_host_checker
bind uep_host uep_host_checker i_uep_host_checker (.CLK_SYS_IN(CLK_SYS_IN), .RSTN_IN(RSTN_IN),
  .CE_IN(CE_IN), .REQ_VALID_IN(REQ_VALID_IN), .REQ_READY_OUT(REQ_READY_OUT),
  .REQ_OP_IN(REQ_OP_IN), .RSP_VALID_OUT(RSP_VALID_OUT),
  .LOCATION_SELECT_LINES_OUT(LOCATION_SELECT_LINES_OUT), .SELECT_N_OUT(SELECT_N_OUT),
  .GATE_N_OUT(GATE_N_OUT), .PROG_SUPPLY_HIGH_OUT(PROG_SUPPLY_HIGH_OUT),
  .SIGNATURE_TRIGGER_HIGH_OUT(SIGNATURE_TRIGGER_HIGH_OUT), .BYTE_LINES_OE_OUT(BYTE_LINES_OE_OUT));
`default_nettype wire

// ==== tb_uep_host.sv ====
// testbench: host port controller against a behavioural eprom
`timescale 1ns/1ps
`default_nettype none
module tb_uep_host;
  localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
  localparam logic [7:0] PART = 8'hC3; // arbitrary value
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic valid = 1'b0;
  logic [1:0] op = 2'h0;
  logic [18:0] addr = 19'h00000;
  logic [7:0] wdata = 8'h00;
  logic ready, rsp, sel_n, gate_n, vpp, trig, oe, err;
  logic [7:0] rdata, hout, mout, q;
  logic [18:0] pins;
  wire [7:0] bus = oe ? hout : mout;
  int fails = 0;
  int check_count = 0;
  always #5 clk = ~clk;
  uep_host #(.PROG_PULSE_CYC(20)) i_uep_host (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .CE_IN(ce),
    .REQ_VALID_IN(valid), .REQ_READY_OUT(ready), .REQ_OP_IN(op), .REQ_ADDR_IN(addr),
    .REQ_WDATA_IN(wdata), .RSP_VALID_OUT(rsp), .RSP_RDATA_OUT(rdata), .RSP_ERR_OUT(err),
    .LOCATION_SELECT_LINES_OUT(pins), .SELECT_N_OUT(sel_n), .GATE_N_OUT(gate_n),
    .PROG_SUPPLY_HIGH_OUT(vpp), .SIGNATURE_TRIGGER_HIGH_OUT(trig), .BYTE_LINES_IN(bus),
    .BYTE_LINES_OUT(hout), .BYTE_LINES_OE_OUT(oe));
  uep_eprom_model #(.MAKER(MAKER), .PART(PART)) i_uep_eprom_model (.a_in(pins),
    .sel_n_in(sel_n), .gate_n_in(gate_n), .vpp_in(vpp), .trig_in(trig), .dq_in(bus),
    .dq_out(mout));
  task automatic final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: pin %b, want %b", $time, got, exp);
    end
  endtask : cmp1
  // one request, held until taken, then wait for the answer pulse
  task automatic do_op(input logic [1:0] o, input logic [18:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    valid <= 1'b1;
    op <= o;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    valid <= 1'b0;
    if (n >= 50) begin
      fails++;
      $display("unexpected at %0t: request not taken", $time);
      final_report();
    end
    while (rsp !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    q = rdata;
    if (n >= 20000) begin
      fails++;
      $display("unexpected at %0t: no answer", $time);
      final_report();
    end
  endtask : do_op
  task automatic t_reset;
    cmp1(sel_n, 1'b1);
    cmp1(gate_n, 1'b1);
    cmp1(oe, 1'b0);
    cmp1(vpp, 1'b0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_erased;
    do_op(uep_pkg::OP_READ, 19'h7FFFF, 8'h00);
    cmp8(q, uep_pkg::ERASED_BYTE);
    do_op(uep_pkg::OP_READ, 19'h00000, 8'h00);
    cmp8(q, 8'hFF);
    $display("test erased done");
  endtask : t_erased
  task automatic t_program;
    do_op(uep_pkg::OP_PROG, 19'h40005, 8'hA5);
    cmp1(err, 1'b0);
    do_op(uep_pkg::OP_VERIFY, 19'h40005, 8'h00);
    cmp8(q, 8'hA5);
    do_op(uep_pkg::OP_READ, 19'h40004, 8'h00);
    cmp8(q, 8'hFF);
    do_op(uep_pkg::OP_PROG, 19'h40005, 8'h5A);
    do_op(uep_pkg::OP_READ, 19'h40005, 8'h00);
    cmp8(q, 8'h00);
    $display("test program done");
  endtask : t_program
  task automatic t_signature;
    do_op(uep_pkg::OP_SIGN, 19'h7FFFE, 8'h00);
    cmp8(q, MAKER);
    do_op(uep_pkg::OP_SIGN, 19'h00001, 8'h00);
    cmp8(q, PART);
    $display("test signature done");
  endtask : t_signature
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_erased();
    t_program();
    t_signature();
    final_report();
  end
endmodule : tb_uep_host
`default_nettype wire
